/* File: src/wdt_ctl_pkg.sv */
// Constants for the watchdog and CPU bus-error control block.
// Assumes a 32-bit AHB-Lite register slave in one system clock domain.
package wdt_ctl_pkg;
   // Register byte offsets
   localparam logic [7:0] CTRL_OFF     = 8'h00;
   localparam logic [7:0] IRQ_STAT_OFF = 8'h04;
   localparam logic [7:0] IRQ_MASK_OFF = 8'h08;
   // Control register field positions
   localparam int RD_EXC_DIS_BIT = 7;
   localparam int WD_EN_BIT      = 6;
   localparam int WD_STAT_BIT    = 5;
   localparam int CPU_BE_EN_BIT  = 4;
   localparam int IP_TO_EN_BIT   = 3;
   localparam int CTRL_W         = 8;
   // Control reset value: both error enables and watchdog enable set
   localparam logic [7:0] CTRL_RST = 8'h58;
   // Interrupt status and mask layout
   localparam int IRQ_WD_BIT = 0;
   localparam int IRQ_BE_BIT = 1;
   localparam int IRQ_W      = 2;
   localparam logic [1:0] IRQ_MASK_RST = 2'h0;
   // AHB constants
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage : wdt_ctl_pkg

/* File: src/sticky_flag.sv */
// Sticky event flag with software clear; a set in the clear cycle wins.
// Assumes reset already synchronised to clk_in.
`timescale 1ns/100ps
module sticky_flag (
   input  wire logic clk_in,
   input  wire logic rst_b_in,
   input  wire logic set_in,
   input  wire logic clr_in,
   output logic      flag_out
);
   logic flag_ff;

   // Set has priority over clear
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         flag_ff <= 1'b0;
      end else if (set_in) begin
         flag_ff <= 1'b1;
      end else if (clr_in) begin
         flag_ff <= 1'b0;
      end
   end

   assign flag_out = flag_ff;
endmodule : sticky_flag

/* File: src/wdt_ctl.sv */
// Watchdog and CPU bus-error supervisory control with AHB-Lite registers.
// Assumes overflow and error inputs are one-cycle pulses synchronous to
// clk_in, and the boot strap is stable around reset release.
`timescale 1ns/100ps
module wdt_ctl (
   input  wire logic        clk_in,
   input  wire logic        rst_b_in,
   // AHB-Lite slave
   input  wire logic        hsel_in,
   input  wire logic [31:0] haddr_in,
   input  wire logic [1:0]  htrans_in,
   input  wire logic        hwrite_in,
   input  wire logic [2:0]  hsize_in,
   input  wire logic [31:0] hwdata_in,
   input  wire logic        hready_in,
   output logic [31:0]      hrdata_out,
   output logic             hreadyout_out,
   output logic             hresp_out,
   // Supervisory events
   input  wire logic        pci_boot_in,
   input  wire logic        wd_overflow_in,
   input  wire logic        cpu_timeout_in,
   input  wire logic        cpu_undecoded_in,
   input  wire logic        cpu_write_in,
   // Toward the CPU core
   output logic             warm_rst_out,
   output logic             bus_err_out,
   output logic             access_term_out,
   output logic             ip_timeout_en_out,
   output logic             irq_out
);
   logic              rst_meta_ff;
   logic              rst_b_ff;
   logic              strap_done_ff;
   logic              pci_boot_ff;
   logic [7:0]        ctrl_ff;
   logic [1:0]        mask_ff;
   logic [1:0]        stat;
   logic              wd_stat;
   logic              wr_pend_ff;
   logic [7:0]        wr_addr_ff;
   logic [31:0]       hrdata_ff;
   logic [31:0]       nxt_rdata;
   logic              addr_ok;
   logic              ctrl_wr;
   logic              stat_wr;
   logic              live;
   logic              wd_en_eff;
   logic              be_en_eff;
   logic              wd_evt;
   logic              be_evt;
   logic              warm_rst_ff;
   logic              bus_err_ff;
   logic              term_ff;

   ////////////////////////////////////////////////////////////////////////
   // Reset release through two flops
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rst_meta_ff <= 1'b0;
         rst_b_ff    <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_b_ff    <= rst_meta_ff;
      end
   end

   // Boot strap caught on first edge after release
   always_ff @(posedge clk_in or negedge rst_b_ff) begin
      if (!rst_b_ff) begin
         strap_done_ff <= 1'b0;
         pci_boot_ff   <= 1'b0;
      end else if (!strap_done_ff) begin
         strap_done_ff <= 1'b1;
         pci_boot_ff   <= pci_boot_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // AHB-Lite address phase capture
   assign addr_ok = hsel_in && hready_in && htrans_in[1];

   always_ff @(posedge clk_in or negedge rst_b_ff) begin
      if (!rst_b_ff) begin
         wr_pend_ff <= 1'b0;
         wr_addr_ff <= 8'h00;
      end else begin
         wr_pend_ff <= addr_ok && hwrite_in;
         wr_addr_ff <= haddr_in[7:0];
      end
   end

   // Write strobes in the data phase
   assign ctrl_wr = wr_pend_ff && (wr_addr_ff == wdt_ctl_pkg::CTRL_OFF);
   assign stat_wr = wr_pend_ff && (wr_addr_ff == wdt_ctl_pkg::IRQ_STAT_OFF);

   // Read data for the addressed register
   always_comb begin
      nxt_rdata = 32'h0000_0000;
      if (haddr_in[7:0] == wdt_ctl_pkg::CTRL_OFF) begin
         nxt_rdata[7:0] = ctrl_ff;
         nxt_rdata[wdt_ctl_pkg::WD_STAT_BIT] = wd_stat;
      end else if (haddr_in[7:0] == wdt_ctl_pkg::IRQ_STAT_OFF) begin
         nxt_rdata[1:0] = stat;
      end else if (haddr_in[7:0] == wdt_ctl_pkg::IRQ_MASK_OFF) begin
         nxt_rdata[1:0] = mask_ff;
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_ff) begin
      if (!rst_b_ff) begin
         hrdata_ff <= 32'h0000_0000;
      end else if (addr_ok && !hwrite_in) begin
         hrdata_ff <= nxt_rdata;
      end
   end

   assign hrdata_out    = hrdata_ff;
   assign hreadyout_out = 1'b1;
   assign hresp_out     = 1'b0;

   ////////////////////////////////////////////////////////////////////////
   // Control and mask registers
   always_ff @(posedge clk_in or negedge rst_b_ff) begin
      if (!rst_b_ff) begin
         ctrl_ff <= wdt_ctl_pkg::CTRL_RST;
      end else if (ctrl_wr) begin
         ctrl_ff <= hwdata_in[7:0];
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_ff) begin
      if (!rst_b_ff) begin
         mask_ff <= wdt_ctl_pkg::IRQ_MASK_RST;
      end else if (wr_pend_ff
                   && wr_addr_ff == wdt_ctl_pkg::IRQ_MASK_OFF) begin
         mask_ff <= hwdata_in[1:0];
      end
   end

   // Enables held off in PCI boot and until strap is known
   assign live = strap_done_ff && !pci_boot_ff;
   assign wd_en_eff = live && ctrl_ff[wdt_ctl_pkg::WD_EN_BIT];
   assign be_en_eff = live && ctrl_ff[wdt_ctl_pkg::CPU_BE_EN_BIT];
   assign ip_timeout_en_out = live
                              && ctrl_ff[wdt_ctl_pkg::IP_TO_EN_BIT];

   // Events
   assign wd_evt = wd_overflow_in && wd_en_eff;
   assign be_evt = (cpu_timeout_in || cpu_undecoded_in)
                   && be_en_eff;

   ////////////////////////////////////////////////////////////////////////
   // Watchdog reset status: set by hardware, cleared by writing zero
   sticky_flag u_wd_stat (
      .clk_in   (clk_in),
      .rst_b_in (rst_b_ff),
      .set_in   (wd_evt),
      .clr_in   (ctrl_wr
                 && !hwdata_in[wdt_ctl_pkg::WD_STAT_BIT]),
      .flag_out (wd_stat)
   );

   // Interrupt status bits, write one to clear
   sticky_flag u_irq_wd (
      .clk_in   (clk_in),
      .rst_b_in (rst_b_ff),
      .set_in   (wd_evt),
      .clr_in   (stat_wr && hwdata_in[wdt_ctl_pkg::IRQ_WD_BIT]),
      .flag_out (stat[wdt_ctl_pkg::IRQ_WD_BIT])
   );

   sticky_flag u_irq_be (
      .clk_in   (clk_in),
      .rst_b_in (rst_b_ff),
      .set_in   (be_evt),
      .clr_in   (stat_wr && hwdata_in[wdt_ctl_pkg::IRQ_BE_BIT]),
      .flag_out (stat[wdt_ctl_pkg::IRQ_BE_BIT])
   );

   // Level interrupt from unmasked status
   assign irq_out = |(stat & mask_ff);

   ////////////////////////////////////////////////////////////////////////
   // Pulses toward the CPU core
   always_ff @(posedge clk_in or negedge rst_b_ff) begin
      if (!rst_b_ff) begin
         warm_rst_ff <= 1'b0;
         bus_err_ff  <= 1'b0;
         term_ff     <= 1'b0;
      end else begin
         warm_rst_ff <= wd_evt;
         term_ff     <= be_evt;
         bus_err_ff  <= be_evt && !cpu_write_in
                        && !ctrl_ff[wdt_ctl_pkg::RD_EXC_DIS_BIT];
      end
   end

   assign warm_rst_out    = warm_rst_ff;
   assign bus_err_out     = bus_err_ff;
   assign access_term_out = term_ff;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_b_ff);

   sequence s_wd_fire;
      wd_overflow_in && wd_en_eff;
   endsequence

   sequence s_rd_err;
      (cpu_timeout_in || cpu_undecoded_in) && be_en_eff && !cpu_write_in
      && !ctrl_ff[wdt_ctl_pkg::RD_EXC_DIS_BIT];
   endsequence

   a_wd_warm_rst: assert property (
      s_wd_fire |=> warm_rst_out ##1 (!warm_rst_out || $past(wd_evt)))
      else $error("Watchdog overflow gave no warm reset");

   a_wd_disabled: assert property (
      warm_rst_out |-> $past(wd_overflow_in)
                       && $past(ctrl_ff[wdt_ctl_pkg::WD_EN_BIT]))
      else $error("Warm reset without enabled overflow");

   a_wd_stat_set: assert property (
      s_wd_fire |=> wd_stat && stat[wdt_ctl_pkg::IRQ_WD_BIT])
      else $error("Watchdog status not set");

   a_wd_stat_hold: assert property (
      wd_stat && !(ctrl_wr && !hwdata_in[wdt_ctl_pkg::WD_STAT_BIT])
      |=> wd_stat)
      else $error("Watchdog status dropped without clear");

   a_wd_stat_one: assert property (
      !wd_stat && !wd_evt && ctrl_wr |=> !wd_stat)
      else $error("Software write set watchdog status");

   a_be_read_err: assert property (
      s_rd_err |=> bus_err_out && access_term_out
                   && stat[wdt_ctl_pkg::IRQ_BE_BIT])
      else $error("Read bus error not raised");

   a_be_undecoded: assert property (
      cpu_undecoded_in && be_en_eff |=> access_term_out)
      else $error("Undecodable access not terminated");

   a_be_exc_dis: assert property (
      be_evt && ctrl_ff[wdt_ctl_pkg::RD_EXC_DIS_BIT]
      |=> access_term_out && !bus_err_out)
      else $error("Bus error sent while exception disabled");

   a_be_write: assert property (
      be_evt && cpu_write_in |=> !bus_err_out
                                 && stat[wdt_ctl_pkg::IRQ_BE_BIT])
      else $error("Write bus error raised an exception");

   a_pci_boot: assert property (
      pci_boot_ff |-> !warm_rst_out && !access_term_out
                      && !ip_timeout_en_out)
      else $error("Function active in PCI boot mode");
endmodule : wdt_ctl

/* File: tb/cpu_core_model.sv */
// CPU core stand-in that counts the supervisory pulses it receives.
// Assumes the pulses are registered one-cycle strobes on clk_in.
`timescale 1ns/100ps
module cpu_core_model (
   input  wire logic clk_in,
   input  wire logic rst_b_in,
   input  wire logic warm_rst_in,
   input  wire logic bus_err_in,
   output int        warm_cnt_out,
   output int        err_cnt_out
);
   // Count each warm reset and read exception taken by the core
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         warm_cnt_out <= 0;
         err_cnt_out  <= 0;
      end else begin
         warm_cnt_out <= warm_cnt_out + int'(warm_rst_in);
         err_cnt_out  <= err_cnt_out + int'(bus_err_in);
      end
   end
endmodule : cpu_core_model

/* File: tb/tb_watchdog_bus_timeout_control.sv */
// Self-checking bench: AHB master, event driver and register model.
// Assumes a zero-wait slave whose hreadyout is fed back as hready.
`timescale 1ns/100ps
module tb_watchdog_bus_timeout_control;
   logic        clk_in = 0, rst_b = 0, hsel = 0, hwrite = 0, boot = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
   logic [1:0]  htrans = 0;
   logic        wd_ovf = 0, tmo = 0, undec = 0, cpu_wr = 0;
   logic        hready, hresp, warm, berr, term, ip_en, irq;
   int          warm_cnt, err_cnt, exp_warm, exp_err, op, d, seed;
   int          ctrl_m, stat_m, mask_m, miscompares, total_checks;
   ////////////////////////////////////////////////////////////////////////
   always #20 clk_in = ~clk_in;
   wdt_ctl dut (.clk_in(clk_in), .rst_b_in(rst_b), .hsel_in(hsel),
      .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
      .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready),
      .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
      .pci_boot_in(boot), .wd_overflow_in(wd_ovf), .cpu_timeout_in(tmo),
      .cpu_undecoded_in(undec), .cpu_write_in(cpu_wr),
      .warm_rst_out(warm), .bus_err_out(berr), .access_term_out(term),
      .ip_timeout_en_out(ip_en), .irq_out(irq));
   cpu_core_model core (.clk_in(clk_in), .rst_b_in(rst_b),
      .warm_rst_in(warm), .bus_err_in(berr), .warm_cnt_out(warm_cnt),
      .err_cnt_out(err_cnt));
   ////////////////////////////////////////////////////////////////////////
   // Verdict and run end
   task give_verdict;
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : give_verdict
   // One comparison
   task chk(input logic ok, input string m);
      total_checks++;
      if (ok !== 1'b1) begin
         miscompares++;
         $display("mismatch at %0t: %s", $time, m);
      end
   endtask : chk
   // Single AHB transfer, entered and left just after a rising edge
   task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= wdt_ctl_pkg::HTRANS_NONSEQ;
      hwrite <= w;
      do begin @(posedge clk_in); n++; end while (hready !== 1'b1 && n < 64);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do begin @(posedge clk_in); n++; end while (hready !== 1'b1 && n < 64);
      r = hrdata;
      chk(n < 64 && hresp === 1'b0, "bus wait");
      if (n >= 64) give_verdict();
   endtask : ahb
   // Read back all registers and level outputs against the model
   task rd_all;
      ahb(0, wdt_ctl_pkg::CTRL_OFF, 0);
      chk(r[7:3] === ctrl_m[7:3], "ctrl");
      ahb(0, wdt_ctl_pkg::IRQ_STAT_OFF, 0);
      chk(r[1:0] === stat_m[1:0], "status");
      ahb(0, wdt_ctl_pkg::IRQ_MASK_OFF, 0);
      chk(r[1:0] === mask_m[1:0], "mask");
      chk(irq === |(stat_m[1:0] & mask_m[1:0]), "irq level");
      chk(ip_en === (ctrl_m[3] & !boot), "ip enable");
   endtask : rd_all
   // One event cycle from the CPU side and its registered answer
   task ev(input logic [2:0] k, input logic w);
      logic xw, xt, xb;
      {undec, tmo, wd_ovf} <= k;
      cpu_wr <= w;
      @(posedge clk_in);
      {undec, tmo, wd_ovf} <= 3'h0;
      xw = k[0] & ctrl_m[6] & !boot;
      xt = (k[1] | k[2]) & ctrl_m[4] & !boot;
      xb = xt & !w & !ctrl_m[7];
      stat_m = stat_m | {xt, xw};
      if (xw) ctrl_m[5] = 1;
      exp_warm += xw;
      exp_err += xb;
      #1;
      chk(warm === xw, "warm reset");
      chk(term === xt, "terminate");
      chk(berr === xb, "bus error");
      chk(irq === |(stat_m[1:0] & mask_m[1:0]), "irq");
      @(posedge clk_in);
   endtask : ev
   // Reset with a chosen boot strap; model returns to defaults
   task do_reset(input logic b);
      rst_b <= 1'b0;
      boot <= b;
      repeat (8) @(posedge clk_in);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk_in);
      {ctrl_m, stat_m, mask_m, exp_warm, exp_err} = {32'h58, 128'h0};
   endtask : do_reset
   // Random register traffic and events under both boot modes
   task run(input int cnt);
      repeat (cnt) begin
         op = $unsigned($random(seed)) % 8;
         d = $random(seed) & 32'hFF;
         case (op)
            0: begin
               ahb(1, wdt_ctl_pkg::CTRL_OFF, d);
               ctrl_m = (d & 32'hD8) | (ctrl_m & d & 32'h20);
            end
            1: begin
               ahb(1, wdt_ctl_pkg::IRQ_STAT_OFF, d);
               stat_m = stat_m & ~d;
            end
            2: begin
               ahb(1, wdt_ctl_pkg::IRQ_MASK_OFF, d);
               mask_m = d & 3;
            end
            default: ev(d[2:0], d[3]);
         endcase
         rd_all();
      end
   endtask : run
   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      seed = 32'h83AE;
      do_reset(0);
      rd_all();
      ahb(1, 8'h0C, 32'hFF);
      ahb(0, 8'h0C, 0);
      chk(r === 32'h00000000, "unmapped");
      // Two watchdog overflows on successive cycles
      wd_ovf <= 1'b1;
      @(posedge clk_in);
      #1;
      chk(warm === 1'b1, "first warm reset");
      @(posedge clk_in);
      wd_ovf <= 1'b0;
      #1;
      chk(warm === 1'b1, "second warm reset");
      @(posedge clk_in);
      stat_m = stat_m | 1;
      ctrl_m[5] = 1;
      exp_warm += 2;
      run(120);
      @(posedge clk_in);
      chk(warm_cnt === exp_warm && err_cnt === exp_err, "core count");
      do_reset(1);
      rd_all();
      run(40);
      @(posedge clk_in);
      chk(warm_cnt === exp_warm && err_cnt === exp_err, "boot count");
      give_verdict();
   end
endmodule : tb_watchdog_bus_timeout_control
